// file: src/rsc_consts.vh
// Constants for the reset source controller
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RSC_CAUSE_ADDR      8'hef
`define RSC_BIT_PIN         0
`define RSC_BIT_POWER       1
`define RSC_BIT_CLKLOSS     2
`define RSC_BIT_WDOG        3
`define RSC_BIT_SOFT        4
`define RSC_BIT_COMP        5
`define RSC_BIT_FLASH       6
`define RSC_CAUSE_W         7
`define RSC_CAUSE_NONE      7'h00
`define RSC_CAUSE_POR       7'h02
`define RSC_MCD_EN_RST      1'b0
`define RSC_ZERO_BIT        1'b0

// ----------------------------------------------------------------
// Address limits
// ----------------------------------------------------------------
`define RSC_USER_TOP        16'h1dff
`define RSC_EXEC_ADDR       16'h0000

// ----------------------------------------------------------------
// Timing, clock period in ns
// ----------------------------------------------------------------
`define RSC_CLK_NS          50
`define RSC_MCD_TIMEOUT_NS  100000
`define RSC_REL_DELAY_NS    5000
`define RSC_MCD_CYC  ((`RSC_MCD_TIMEOUT_NS+`RSC_CLK_NS-1)/`RSC_CLK_NS)
`define RSC_REL_CYC  ((`RSC_REL_DELAY_NS+`RSC_CLK_NS-1)/`RSC_CLK_NS)
`define RSC_WDT_DIV         12
`define RSC_MCD_CNT_W       12
`define RSC_REL_CNT_W       7
`define RSC_WDT_CNT_W       4

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
`define RSC_ST_RUN          2'h0
`define RSC_ST_HOLD         2'h1
`define RSC_ST_DELAY        2'h2

`endif

// file: src/rsc_sync2.v
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
`default_nettype none

module rsc_sync2 #(
    parameter [0:0] RST_VAL = 1'b0  // Level held during reset
) (
    input  wire clk_sys,  // System clock
    input  wire rst_b,    // Async reset, active low
    input  wire async_i,  // Level from outside the domain
    output wire sync_o    // Synchronised level
);

// ----------------------------------------------------------------
// Synchroniser pair
// ----------------------------------------------------------------
reg meta_q;  // First stage, read only by the second
reg sync_q;  // Second stage

// Reset value is a parameter, so the reset branch stays constant
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        meta_q <= RST_VAL;
        sync_q <= RST_VAL;
    end else begin
        meta_q <= async_i;
        sync_q <= meta_q;
    end
end

assign sync_o = sync_q;

endmodule
`default_nettype wire

// file: src/rsc_reset_source_controller.v
// Reset source controller: cause register, sources and release delay
//
// Operation
// - Clock stuck past timeout resets when enabled
// - Clock-loss flag reads one only after it
// - Writing bit 2 enables/disables clock-loss detector
// - Internal sources other than the supply monitor never drive reset pin
// - Writing bit 5 selects comparator reset source
// - Selected comparator low resets device; the reset clears the selection
// - Comparator flag reads one only after it
// - Watchdog enabled, clocked system clock/12 after reset
// - Watchdog expiry resets and sets bit 3
// - Program-store data write above limit resets
// - Code-space read above limit resets
// - Branch fetch above limit resets
// - Security-denied flash access resets
// - Flash error bit 6, read-only, marks it
// - Writing one to bit 4 forces reset
// - Bit 7 reads zero, ignores writes
// - Bit 1 power flag; write selects supply monitor
// - Bit 0 marks external pin reset
// - Wait 5.0 us before executing at 0x0000
// - Other resets clear the power flag
// - Supply monitor selection kept except power-on
`include "rsc_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module rsc_reset_source_controller (
    input  wire        clk_sys,        // System clock, 20 MHz
    input  wire        rst_b,          // Power-on reset, active low
    input  wire        rst_pin_i,      // External reset pin level
    output reg         rst_pin_o,      // Pin drive value, always low
    output reg         rst_pin_oe,     // Pin driven while high
    input  wire        clk_mon_i,      // Monitored system clock copy
    input  wire        comp_out_i,     // Comparator output, async
    input  wire        vdd_ok_i,       // Supply monitor output, async
    input  wire        wdog_expire,    // Watchdog expiry pulse
    input  wire        pgm_wr_en,      // Program-store write enable
    input  wire        dmove_wr,       // Data-space write strobe
    input  wire [15:0] dmove_addr,     // Data-space write address
    input  wire        code_rd,        // Code-space read strobe
    input  wire [15:0] code_addr,      // Code-space read address
    input  wire        branch_fetch,   // Branch fetch strobe
    input  wire [15:0] branch_addr,    // Branch target address
    input  wire        sec_deny,       // Flash access denied pulse
    input  wire [7:0]  sfr_addr,       // Register address
    input  wire        sfr_wr,         // Register write strobe
    input  wire [7:0]  sfr_wdata,      // Register write data
    output reg  [7:0]  sfr_rdata,      // Register read data
    output reg         core_rst_b,     // Core reset, active low
    output reg         exec_start,     // Start fetch pulse
    output reg  [15:0] exec_addr,      // First fetch address
    output reg         wdog_force_en,  // Watchdog forced on
    output reg         wdog_tick,      // Watchdog clock enable
    output reg         vdd_sel,        // Supply monitor as source
    output reg         comp_sel,       // Comparator as source
    output reg         mcd_en          // Clock-loss detector on
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
wire pin_s;   // Pin level, synchronised
wire comp_s;  // Comparator output, synchronised
wire vdd_s;   // Supply good, synchronised
wire mon_s;   // Monitored clock, synchronised

rsc_sync2 #(.RST_VAL(1'b1)) u_sync_pin (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .async_i (rst_pin_i),
    .sync_o  (pin_s)
);

rsc_sync2 #(.RST_VAL(1'b1)) u_sync_comp (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .async_i (comp_out_i),
    .sync_o  (comp_s)
);

rsc_sync2 #(.RST_VAL(1'b1)) u_sync_vdd (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .async_i (vdd_ok_i),
    .sync_o  (vdd_s)
);

rsc_sync2 #(.RST_VAL(1'b0)) u_sync_mon (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .async_i (clk_mon_i),
    .sync_o  (mon_s)
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
localparam [31:0] MCD_CYC_F = `RSC_MCD_CYC;      // Full-width counts,
localparam [31:0] REL_CYC_F = `RSC_REL_CYC - 1;  // cut to the counter
localparam [31:0] WDT_DIV_F = `RSC_WDT_DIV - 1;  // widths below
localparam [`RSC_MCD_CNT_W-1:0] MCD_LIM =
    MCD_CYC_F[`RSC_MCD_CNT_W-1:0];         // Stuck-clock cycles
localparam [`RSC_REL_CNT_W-1:0] REL_LIM =
    REL_CYC_F[`RSC_REL_CNT_W-1:0];         // Release delay, last
localparam [`RSC_WDT_CNT_W-1:0] WDT_LIM =
    WDT_DIV_F[`RSC_WDT_CNT_W-1:0];         // Divider last count

reg  [1:0]                state_q;     // Sequencer state
reg  [1:0]                state_d;     // Next state
reg  [`RSC_CAUSE_W-1:0]   cause_q;     // Latched cause flags
reg  [`RSC_CAUSE_W-1:0]   cause_d;     // Next cause flags
reg  [`RSC_MCD_CNT_W-1:0] mcd_cnt_q;   // Cycles since clock edge
reg                       mon_last_q;  // Monitored clock, last
reg  [`RSC_REL_CNT_W-1:0] rel_cnt_q;   // Release delay counter
reg  [`RSC_WDT_CNT_W-1:0] wdt_cnt_q;   // Watchdog divider
reg                       soft_q;      // Software force pending
reg                       por_q;       // Power-on drive active
reg  [1:0]                pin_own_q;   // Own pin drive, delayed
wire                      pin_mine;    // Low pin level is our own
reg  [`RSC_CAUSE_W-1:0]   src;         // Active sources now
wire                      cause_wr;    // Write to cause register
wire                      flash_err;   // Illegal flash access
wire                      mcd_hit;     // Clock stuck too long

assign cause_wr = sfr_wr && (sfr_addr == `RSC_CAUSE_ADDR);

// ----------------------------------------------------------------
// Source detection
// ----------------------------------------------------------------
// Any one of the illegal accesses; only meaningful while running
assign flash_err =
    (pgm_wr_en && dmove_wr && (dmove_addr > `RSC_USER_TOP))
    || (code_rd && (code_addr > `RSC_USER_TOP))
    || (branch_fetch && (branch_addr > `RSC_USER_TOP))
    || sec_deny;

assign mcd_hit = mcd_en && (mcd_cnt_q >= MCD_LIM);

// Our own drive loops back through the pin; mask it while the
// synchroniser still carries it, or power-on would never end
assign pin_mine = rst_pin_oe || pin_own_q[1];

// Gather all sources; the pulse ones only count while running,
// level ones except the comparator hold the device in reset while true
always @* begin
    src = `RSC_CAUSE_NONE;
    src[`RSC_BIT_PIN]     = !pin_s && !pin_mine;
    src[`RSC_BIT_POWER]   = vdd_sel && !vdd_s;
    src[`RSC_BIT_CLKLOSS] = mcd_hit;
    src[`RSC_BIT_COMP]    = comp_sel && !comp_s;
    if (state_q == `RSC_ST_RUN) begin
        src[`RSC_BIT_WDOG]  = wdog_expire;
        src[`RSC_BIT_SOFT]  = soft_q;
        src[`RSC_BIT_FLASH] = flash_err;
    end
end

// ----------------------------------------------------------------
// Clock-loss one-shot
// ----------------------------------------------------------------
// Counts cycles with no change on the monitored clock; saturates
// so a long stall cannot wrap back to a quiet count
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        mcd_cnt_q  <= {`RSC_MCD_CNT_W{1'b0}};
        mon_last_q <= 1'b0;
    end else begin
        mon_last_q <= mon_s;
        if (mon_s != mon_last_q || !mcd_en) begin
            mcd_cnt_q <= {`RSC_MCD_CNT_W{1'b0}};
        end else if (mcd_cnt_q < MCD_LIM) begin
            mcd_cnt_q <= mcd_cnt_q + 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
// Hold while any source stands, then wait the release delay
always @* begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
        `RSC_ST_RUN: begin
            if (src != `RSC_CAUSE_NONE) begin
                state_d = `RSC_ST_HOLD;
                cause_d = src;
            end
        end
        `RSC_ST_HOLD: begin
            cause_d = cause_q | src;
            if (src == `RSC_CAUSE_NONE) begin
                state_d = `RSC_ST_DELAY;
            end
        end
        `RSC_ST_DELAY: begin
            if (src != `RSC_CAUSE_NONE) begin
                state_d = `RSC_ST_HOLD;
                cause_d = cause_q | src;
            end else if (rel_cnt_q == REL_LIM) begin
                state_d = `RSC_ST_RUN;
            end
        end
        default: begin
            state_d = `RSC_ST_HOLD;
        end
    endcase
end

// State, flags and the release counter
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        state_q   <= `RSC_ST_DELAY;
        cause_q   <= `RSC_CAUSE_POR;
        rel_cnt_q <= {`RSC_REL_CNT_W{1'b0}};
    end else begin
        state_q <= state_d;
        cause_q <= cause_d;          // Other flags cleared
        if (state_q == `RSC_ST_DELAY && state_d == `RSC_ST_DELAY)
        begin
            rel_cnt_q <= rel_cnt_q + 1'b1;
        end else begin
            rel_cnt_q <= {`RSC_REL_CNT_W{1'b0}};
        end
    end
end

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
// Written bits are enables, read bits are causes; they differ
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        vdd_sel  <= 1'b0;
        comp_sel <= 1'b0;
        mcd_en   <= `RSC_MCD_EN_RST;
        soft_q   <= 1'b0;
    end else if (state_q != `RSC_ST_RUN) begin
        // Comparator selection returns off after any reset;
        // supply and clock-loss enables survive all but power-on
        comp_sel <= 1'b0;
        soft_q   <= 1'b0;
    end else if (cause_wr) begin
        mcd_en   <= sfr_wdata[`RSC_BIT_CLKLOSS];
        comp_sel <= sfr_wdata[`RSC_BIT_COMP];
        vdd_sel  <= sfr_wdata[`RSC_BIT_POWER];
        soft_q   <= sfr_wdata[`RSC_BIT_SOFT];
    end else begin
        soft_q   <= 1'b0;
    end
end

// Read data registered one cycle after the address
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        sfr_rdata <= 8'h00;
    end else if (sfr_addr == `RSC_CAUSE_ADDR) begin
        sfr_rdata <= {`RSC_ZERO_BIT, cause_q};
    end else begin
        sfr_rdata <= 8'h00;
    end
end

// ----------------------------------------------------------------
// Outputs to core, pin and watchdog
// ----------------------------------------------------------------
// Pin is driven only for power-on and supply-monitor resets
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        por_q         <= 1'b1;
        pin_own_q     <= 2'b11;
        rst_pin_o     <= 1'b0;
        rst_pin_oe    <= 1'b1;
        core_rst_b    <= 1'b0;
        exec_start    <= 1'b0;
        exec_addr     <= `RSC_EXEC_ADDR;
        wdog_force_en <= 1'b1;
    end else begin
        if (state_d == `RSC_ST_RUN) begin
            por_q <= 1'b0;
        end
        rst_pin_o  <= 1'b0;
        pin_own_q  <= {pin_own_q[0], rst_pin_oe};
        rst_pin_oe <= (por_q && state_d != `RSC_ST_RUN)
                      || src[`RSC_BIT_POWER];
        core_rst_b <= (state_d == `RSC_ST_RUN);
        exec_start <= (state_q == `RSC_ST_DELAY)
                      && (state_d == `RSC_ST_RUN);
        exec_addr  <= `RSC_EXEC_ADDR;
        wdog_force_en <= (state_d != `RSC_ST_RUN);
    end
end

// Watchdog clock enable: one pulse every twelve cycles,
// restarted by each reset so the first period is whole
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        wdt_cnt_q <= {`RSC_WDT_CNT_W{1'b0}};
        wdog_tick <= 1'b0;
    end else if (state_q != `RSC_ST_RUN) begin
        wdt_cnt_q <= {`RSC_WDT_CNT_W{1'b0}};
        wdog_tick <= 1'b0;
    end else if (wdt_cnt_q == WDT_LIM) begin
        wdt_cnt_q <= {`RSC_WDT_CNT_W{1'b0}};
        wdog_tick <= 1'b1;
    end else begin
        wdt_cnt_q <= wdt_cnt_q + 1'b1;
        wdog_tick <= 1'b0;
    end
end

endmodule
`default_nettype wire

// file: dv/rsc_chk.sv
// Assertion checker for the reset source controller ports
`timescale 1ns/1ns
`default_nettype none

module rsc_chk (
    input wire logic        clk_sys,      // System clock
    input wire logic        rst_b,        // Power-on reset
    input wire logic        rst_pin_oe,   // Pin drive enable
    input wire logic        clk_mon_i,    // Monitored clock
    input wire logic        comp_out_i,   // Comparator output
    input wire logic        wdog_expire,  // Watchdog expiry
    input wire logic        pgm_wr_en,    // Program write enable
    input wire logic        dmove_wr,     // Data write strobe
    input wire logic [15:0] dmove_addr,   // Data write address
    input wire logic        code_rd,      // Code read strobe
    input wire logic [15:0] code_addr,    // Code read address
    input wire logic        branch_fetch, // Branch strobe
    input wire logic [15:0] branch_addr,  // Branch target
    input wire logic        sec_deny,     // Denied flash access
    input wire logic [7:0]  sfr_addr,     // Register address
    input wire logic        sfr_wr,       // Register write
    input wire logic [7:0]  sfr_wdata,    // Write data
    input wire logic        core_rst_b,   // Core reset
    input wire logic        exec_start,   // Fetch start pulse
    input wire logic [15:0] exec_addr,    // First fetch address
    input wire logic        wdog_tick,    // Watchdog tick
    input wire logic        comp_sel,     // Comparator selected
    input wire logic        mcd_en        // Detector enabled
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [7:0]  lo_q;     // Cycles held in reset, saturating
    logic [11:0] stuck_q;  // Cycles with a frozen monitored clock
    logic        mon_q;    // Previous monitored clock level
    // Counted from the ports alone, so an early release shows up
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lo_q    <= 8'h00;
            stuck_q <= 12'h000;
            mon_q   <= 1'b0;
        end else begin
            lo_q    <= core_rst_b ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};
            stuck_q <= (!mcd_en || clk_mon_i != mon_q) ? 12'h000 :
                       stuck_q + {11'h000, stuck_q != 12'hfff};
            mon_q   <= clk_mon_i;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Any illegal or denied flash access while running
    sequence s_flash_req;
        core_rst_b && ((pgm_wr_en && dmove_wr && dmove_addr > 16'h1dff)
        || (code_rd && code_addr > 16'h1dff) || sec_deny
        || (branch_fetch && branch_addr > 16'h1dff));
    endsequence
    property p_flash_rst;
        s_flash_req |=> !core_rst_b;
    endproperty
    a_flash_rst: assert property (p_flash_rst)
        else $error("flash fault gave no reset");
    property p_wdog_rst;
        core_rst_b && wdog_expire |=> !core_rst_b;
    endproperty
    a_wdog_rst: assert property (p_wdog_rst)
        else $error("watchdog expiry gave no reset");
    property p_pin_quiet;
        core_rst_b && (wdog_expire || sec_deny) |=> (!rst_pin_oe)[*4];
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("internal reset drove the pin");
    property p_soft_rst;
        core_rst_b && sfr_wr && sfr_addr == 8'hef && sfr_wdata[4]
            |-> ##[1:2] !core_rst_b;
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("software force gave no reset");
    property p_rel_wait;
        $rose(core_rst_b) |-> lo_q >= 8'h64;
    endproperty
    a_rel_wait: assert property (p_rel_wait)
        else $error("reset released too early");
    property p_exec_zero;
        exec_start |-> $rose(core_rst_b) && exec_addr == 16'h0000;
    endproperty
    a_exec_zero: assert property (p_exec_zero)
        else $error("fetch start wrong");
    property p_wdog_div;
        wdog_tick |-> ##12 (wdog_tick || !core_rst_b);
    endproperty
    a_wdog_div: assert property (p_wdog_div)
        else $error("watchdog tick period wrong");
    property p_comp_rst;
        core_rst_b && comp_sel && !comp_out_i |-> ##[1:4] !core_rst_b;
    endproperty
    a_comp_rst: assert property (p_comp_rst)
        else $error("comparator low gave no reset");
    property p_clk_loss;
        core_rst_b && stuck_q == 12'h7d0 |-> ##[0:8] !core_rst_b;
    endproperty
    a_clk_loss: assert property (p_clk_loss)
        else $error("frozen clock gave no reset");
endmodule

`default_nettype wire

// file: dv/rsc_far_model.sv
// Far-side model: reset pin, comparator, supply and clock copy
`timescale 1ns/1ns
`default_nettype none

module rsc_far_model #(
    parameter PIN_CYC  = 300,  // Pin low time, 15 us at 50 ns
    parameter COMP_CYC = 20    // Comparator low time
) (
    input  wire logic clk_sys,    // System clock
    input  wire logic pin_req,    // Pull the pin low
    input  wire logic comp_req,   // Drop the comparator output
    input  wire logic clk_stop,   // Freeze the clock copy
    output var  logic pin_rel,    // High while pin released
    output var  logic comp_out_i, // Comparator output
    output var  logic vdd_ok_i,   // Supply above threshold
    output var  logic clk_mon_i   // Monitored clock copy
);
    int pin_cnt  = 0;  // Cycles left with pin held low
    int comp_cnt = 0;  // Cycles left with comparator low
    initial clk_mon_i = 1'b0;
    assign pin_rel    = (pin_cnt == 0);
    assign comp_out_i = (comp_cnt == 0);
    assign vdd_ok_i   = 1'b1;  // Supply stays healthy in this bench
    // Pin is never released early, so a reset is always guaranteed
    always @(posedge clk_sys) begin
        pin_cnt   <= pin_req ? PIN_CYC : pin_cnt - (pin_cnt > 0);
        comp_cnt  <= comp_req ? COMP_CYC : comp_cnt - (comp_cnt > 0);
        clk_mon_i <= clk_stop ? clk_mon_i : ~clk_mon_i;
    end
endmodule

`default_nettype wire

// file: dv/rsc_tb.sv
// Testbench for the reset source controller
`timescale 1ns/1ns
`default_nettype none

module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_sys = 1'b0, rst_b = 1'b0, pgm_wr_en = 1'b0;
    logic        dmove_wr = 1'b0, code_rd = 1'b0, branch_fetch = 1'b0;
    logic        sec_deny = 1'b0, wdog_expire = 1'b0, sfr_wr = 1'b0;
    logic        pin_req = 1'b0, comp_req = 1'b0, clk_stop = 1'b0;
    logic [15:0] dmove_addr = 16'h0000, code_addr = 16'h0000;
    logic [15:0] branch_addr = 16'h0000;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00;
    wire         rst_pin_i, rst_pin_o, rst_pin_oe, pin_rel, clk_mon_i;
    wire         comp_out_i, vdd_ok_i, core_rst_b, exec_start, mcd_en;
    wire         wdog_force_en, wdog_tick, vdd_sel, comp_sel;
    wire [15:0]  exec_addr;
    wire [7:0]   sfr_rdata;
    int          failures = 0, comparisons = 0;
    // Wired pin: pulled up, low if either side pulls it
    assign rst_pin_i = pin_rel & ~(rst_pin_oe & ~rst_pin_o);
    always #25 clk_sys = ~clk_sys;

    rsc_reset_source_controller i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .clk_mon_i(clk_mon_i),
        .comp_out_i(comp_out_i), .vdd_ok_i(vdd_ok_i),
        .wdog_expire(wdog_expire), .pgm_wr_en(pgm_wr_en),
        .dmove_wr(dmove_wr), .dmove_addr(dmove_addr), .code_rd(code_rd),
        .code_addr(code_addr), .branch_fetch(branch_fetch),
        .branch_addr(branch_addr), .sec_deny(sec_deny),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .core_rst_b(core_rst_b),
        .exec_start(exec_start), .exec_addr(exec_addr),
        .wdog_force_en(wdog_force_en), .wdog_tick(wdog_tick),
        .vdd_sel(vdd_sel), .comp_sel(comp_sel), .mcd_en(mcd_en));
    rsc_far_model i_far (.clk_sys(clk_sys), .pin_req(pin_req),
        .comp_req(comp_req), .clk_stop(clk_stop), .pin_rel(pin_rel),
        .comp_out_i(comp_out_i), .vdd_ok_i(vdd_ok_i),
        .clk_mon_i(clk_mon_i));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a core reset level; a hang ends the run
    task automatic wait_core(input logic lvl);
        int n = 0;
        while (core_rst_b !== lvl && n < 3000) begin
            @(posedge clk_sys);
            #5;
            n++;
        end
        if (core_rst_b !== lvl) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] d);
        {sfr_addr, sfr_wdata, sfr_wr} = {8'hef, d, 1'b1};
        @(posedge clk_sys);
        #5;
        sfr_wr = 1'b0;
        @(posedge clk_sys);
        #5;
    endtask
    // Read data is registered: valid one edge after the address
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        @(posedge clk_sys);
        #5;
        chk(sfr_rdata, exp);
    endtask
    task automatic fire(input logic [4:0] s, input logic [15:0] a);
        {dmove_addr, code_addr, branch_addr} = {a, a, a};
        {wdog_expire, sec_deny, branch_fetch, code_rd, dmove_wr} = s;
        @(posedge clk_sys);
        #5;
        {wdog_expire, sec_deny, branch_fetch, code_rd, dmove_wr} = 5'h00;
    endtask
    task automatic req(input logic [1:0] v);
        {pin_req, comp_req} = v;
        @(posedge clk_sys);
        #5;
        {pin_req, comp_req} = 2'b00;
    endtask
    // Wait out a whole reset, then read the cause flags
    task automatic cause_chk(input logic [7:0] exp);
        wait_core(1'b0);
        wait_core(1'b1);
        rd_chk(8'hef, exp);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        #5;
        chk({5'h00, rst_pin_o, rst_pin_oe, wdog_force_en}, 8'h03);
        rst_b = 1'b1;
        wait_core(1'b1);
        rd_chk(8'hef, 8'h02);
        rd_chk(8'hee, 8'h00);
        wr(8'ha6);
        chk({5'h00, vdd_sel, comp_sel, mcd_en}, 8'h07);
        wr(8'h02);
        chk({5'h00, vdd_sel, comp_sel, mcd_en}, 8'h04);
        wr(8'h12);
        cause_chk(8'h10);
        chk({7'h00, vdd_sel}, 8'h01);
        fire(5'h10, 16'h0000);
        cause_chk(8'h08);
        fire(5'h01, 16'h1e00);
        repeat (4) @(posedge clk_sys);
        #5;
        chk({7'h00, core_rst_b}, 8'h01);
        pgm_wr_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (i < 3) begin
                fire(5'h01 << i, 16'h1dff);
                repeat (4) @(posedge clk_sys);
                #5;
                chk({7'h00, core_rst_b}, 8'h01);
            end
            fire(5'h01 << i, 16'h1e00);
            cause_chk(8'h40);
        end
        pgm_wr_en = 1'b0;
        wr(8'h62);
        rd_chk(8'hef, 8'h40);
        req(2'b01);
        cause_chk(8'h20);
        chk({7'h00, comp_sel}, 8'h00);
        req(2'b10);
        cause_chk(8'h01);
        wr(8'h06);
        clk_stop = 1'b1;
        wait_core(1'b0);
        clk_stop = 1'b0;
        cause_chk(8'h04);
        wr(8'h02);
        chk({7'h00, mcd_en}, 8'h00);
        end_of_test();
    end
endmodule

bind rsc_reset_source_controller rsc_chk i_chk (.clk_sys(clk_sys),
    .rst_b(rst_b), .rst_pin_oe(rst_pin_oe), .clk_mon_i(clk_mon_i),
    .comp_out_i(comp_out_i), .wdog_expire(wdog_expire),
    .pgm_wr_en(pgm_wr_en), .dmove_wr(dmove_wr), .dmove_addr(dmove_addr),
    .code_rd(code_rd), .code_addr(code_addr),
    .branch_fetch(branch_fetch), .branch_addr(branch_addr),
    .sec_deny(sec_deny), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .core_rst_b(core_rst_b),
    .exec_start(exec_start), .exec_addr(exec_addr),
    .wdog_tick(wdog_tick), .comp_sel(comp_sel), .mcd_en(mcd_en));

`default_nettype wire
